// File: dv/apcs_host_model.sv
// Behavioural external audio host driving the serial clock pins
`timescale 1ns/10ps
`default_nettype none
module apcs_host_model (
    // Device side of each two-way pin
    input  wire logic primary_rx_bit_clock_pin_out,
    input  wire logic primary_rx_bit_clock_pin_oe_n,
    input  wire logic primary_rx_frame_clock_pin_out,
    input  wire logic primary_rx_frame_clock_pin_oe_n,
    input  wire logic primary_tx_bit_clock_pin_out,
    input  wire logic primary_tx_bit_clock_pin_oe_n,
    input  wire logic secondary_bit_clock_pin_out,
    input  wire logic secondary_bit_clock_pin_oe_n,
    input  wire logic secondary_frame_clock_pin_out,
    input  wire logic secondary_frame_clock_pin_oe_n,
    // Resolved pin levels
    output var  logic primary_rx_bit_clock_pin_in,
    output var  logic primary_rx_frame_clock_pin_in,
    output var  logic primary_tx_bit_clock_pin_in,
    output var  logic secondary_bit_clock_pin_in,
    output var  logic secondary_frame_clock_pin_in
);
    logic        bclk = 1'b0;
    logic        lrclk = 1'b0;
    int unsigned n = 0;
    // Bit clock 160 ns, frame of 64 bits
    always #80 bclk = ~bclk;
    always @(negedge bclk) begin
        n = (n == 31) ? 0 : n + 1;
        if (n == 0) begin
            lrclk = ~lrclk;
        end
    end
    // Host yields each pin whenever the device drives it
    assign primary_rx_bit_clock_pin_in   = primary_rx_bit_clock_pin_oe_n ? bclk : primary_rx_bit_clock_pin_out;
    assign primary_rx_frame_clock_pin_in = primary_rx_frame_clock_pin_oe_n ? lrclk : primary_rx_frame_clock_pin_out;
    // Inverted so a wrong tx bit clock choice shows
    assign primary_tx_bit_clock_pin_in   = primary_tx_bit_clock_pin_oe_n ? ~bclk : primary_tx_bit_clock_pin_out;
    assign secondary_bit_clock_pin_in    = secondary_bit_clock_pin_oe_n ? bclk : secondary_bit_clock_pin_out;
    assign secondary_frame_clock_pin_in  = secondary_frame_clock_pin_oe_n ? lrclk : secondary_frame_clock_pin_out;
endmodule
`default_nettype wire

// File: dv/tb_apcs_top.sv
// Self-checking bench for the audio port clock select block
`timescale 1ns/10ps
`default_nettype none
module tb_apcs_top;
    import apcs_pkg::*;
    logic              clock, rst, reg_write, reg_read, spdif_rx_enabled;
    logic [6:0]        reg_addr;
    logic [8:0]        reg_wdata, reg_rdata;
    apcs_route_t       primary_tx_route, secondary_tx_route;
    logic              main_clock_pin = 1'b0, adc_main_clock_pin = 1'b0, pll_a_output, pll_b_output = 1'b0;
    logic              primary_rx_bit_clock_pin_in, primary_rx_bit_clock_pin_out, primary_rx_bit_clock_pin_oe_n;
    logic              primary_rx_frame_clock_pin_in, primary_rx_frame_clock_pin_out, primary_rx_frame_clock_pin_oe_n;
    logic              primary_tx_bit_clock_pin_in, primary_tx_bit_clock_pin_out, primary_tx_bit_clock_pin_oe_n;
    logic              secondary_bit_clock_pin_in, secondary_bit_clock_pin_out, secondary_bit_clock_pin_oe_n;
    logic              secondary_frame_clock_pin_in, secondary_frame_clock_pin_out, secondary_frame_clock_pin_oe_n;
    logic              prx_bclk, prx_lrclk, ptx_bclk, ptx_lrclk, sec_bclk, sec_lrclk;
    int                err_total = 0, tests_run = 0, cyc = 0;
    logic [31:0]       seed = 32'h0000_18a5;
    logic [8:0]        d;
    apcs_top        apcs_top_inst (.*);
    apcs_host_model apcs_host_model_inst (.*);
    // Reference clocks; PLL A stays dead so a wrong pick shows
    always #20 main_clock_pin = ~main_clock_pin;
    always #25 adc_main_clock_pin = ~adc_main_clock_pin;
    always #30 pll_b_output = ~pll_b_output;
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [8:0] v);
        @(posedge clock);
        #1 reg_write = 1'b1;
        reg_addr = a;
        reg_wdata = v;
        @(posedge clock);
        #1 reg_write = 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [8:0] exp);
        @(posedge clock);
        #1 reg_read = 1'b1;
        reg_addr = a;
        @(posedge clock);
        #1 reg_read = 1'b0;
        @(posedge clock);
        #1 chk(reg_rdata, exp);
    endtask
    // Slave path: pins reach the port clocks after the synchronisers
    task automatic slave_chk(input logic tx_exp);
        @(posedge primary_rx_bit_clock_pin_in);
        repeat (6) @(posedge clock);
        #1 chk({8'h00, prx_bclk}, 9'h001);
        chk({8'h00, sec_bclk}, 9'h001);
        chk({8'h00, ptx_bclk}, {8'h00, tx_exp});
        chk({7'h00, ptx_lrclk, prx_lrclk}, {7'h00, {2{primary_rx_frame_clock_pin_in}}});
        chk({8'h00, sec_lrclk}, {8'h00, secondary_frame_clock_pin_in});
        chk({8'h00, primary_rx_bit_clock_pin_oe_n}, 9'h001);
    endtask
    // Port view: enable, bit clock pin, selected bit clock
    function automatic logic [2:0] port_view(input int s);
        case (s)
            0:       return {primary_rx_bit_clock_pin_oe_n, primary_rx_bit_clock_pin_out, prx_bclk};
            1:       return {primary_tx_bit_clock_pin_oe_n, primary_tx_bit_clock_pin_out, ptx_bclk};
            default: return {secondary_bit_clock_pin_oe_n, secondary_bit_clock_pin_out, sec_bclk};
        endcase
    endfunction
    // Generator of port s alive or stopped, seen on clock and pin
    task automatic runs(input int s, input logic e);
        int         c;
        int         c_pin;
        logic [2:0] p;
        logic [2:0] w;
        c = 0;
        c_pin = 0;
        repeat (100) @(posedge clock);
        #1 p = port_view(s);
        repeat (300) begin
            @(posedge clock);
            #1 w = port_view(s);
            if (w[0] !== p[0]) c++;
            if (w[1] !== p[1]) c_pin++;
            p = w;
        end
        chk({8'h00, c > 0}, {8'h00, e});
        chk({8'h00, c_pin > 0}, {8'h00, e});
        chk({8'h00, p[2]}, 9'h000);
    endtask
    task final_report;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            final_report;
        end
    end
    initial begin
        {rst, reg_write, reg_read, spdif_rx_enabled, pll_a_output} = 5'b1_0000;
        {reg_addr, reg_wdata} = '0;
        primary_tx_route = APCS_ROUTE_OTHER;
        secondary_tx_route = APCS_ROUTE_OTHER;
        repeat (16) @(posedge clock);
        #1 rst = 1'b0;
        rd(ADDR_CLOCK_SOURCE_SELECT, RST_CLOCK_SOURCE_SELECT);
        rd(ADDR_PRX_CFG, RST_PRX_CFG);
        rd(ADDR_PTX_CFG, RST_PTX_CFG);
        rd(ADDR_SEC_CFG, 9'h0c0);
        rd(7'h0c, 9'h000);
        slave_chk(1'b0);
        wr(ADDR_CLOCK_SOURCE_SELECT, 9'h01c);
        slave_chk(1'b1);
        wr(ADDR_CLOCK_SOURCE_SELECT, RST_CLOCK_SOURCE_SELECT);
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            d = seed[8:0];
            primary_tx_route = apcs_route_t'(seed[10:9]);
            secondary_tx_route = apcs_route_t'(seed[12:11]);
            wr(i[0] ? ADDR_SEC_CFG : ADDR_PTX_CFG, d);
            rd(i[0] ? ADDR_SEC_CFG : ADDR_PTX_CFG, d);
        end
        wr(ADDR_PTX_CFG, RST_PTX_CFG);
        wr(ADDR_SEC_CFG, RST_SEC_CFG);
        // Field, receiver state, expect activity
        for (int i = 0; i < 5; i++) begin
            d = {1'b0, 2'(32'h0000_01b0 >> (2 * i)), 6'h20};
            spdif_rx_enabled = (i == 3);
            wr(ADDR_PRX_CFG, d);
            runs(0, i != 4);
        end
        // Manual override: fields win over forcing and routing; then automatic routing and forcing
        wr(ADDR_CLOCK_SOURCE_SELECT, 9'h050);
        spdif_rx_enabled = 1'b1;
        runs(0, 1'b0);
        primary_tx_route = APCS_ROUTE_SEC_RX;
        wr(ADDR_PTX_CFG, 9'h060);
        runs(1, 1'b0);
        wr(ADDR_CLOCK_SOURCE_SELECT, RST_CLOCK_SOURCE_SELECT);
        runs(1, 1'b1);
        primary_tx_route = APCS_ROUTE_SPDIF_RX;
        runs(1, 1'b0);
        spdif_rx_enabled = 1'b0;
        secondary_tx_route = APCS_ROUTE_PRI_RX;
        wr(ADDR_SEC_CFG, 9'h0e0);
        runs(2, 1'b1);
        secondary_tx_route = APCS_ROUTE_SPDIF_RX;
        runs(2, 1'b0);
        spdif_rx_enabled = 1'b1;
        secondary_tx_route = APCS_ROUTE_OTHER;
        wr(ADDR_SEC_CFG, 9'h060);
        runs(2, 1'b1);
        final_report;
    end
endmodule
`default_nettype wire

// File: rtl/apcs_ref_gen.sv
// Master-mode bit and frame clock generator with safe reference switch
`timescale 1ns/10ps
`default_nettype none
module apcs_ref_gen
    import apcs_pkg::*;
#(
    parameter int unsigned BCLK_HALF = GEN_BCLK_HALF,
    parameter int unsigned LR_HALF   = GEN_LR_HALF
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // Control side
    apcs_gen_if.gen   gif
);
    localparam int unsigned HW = (BCLK_HALF > 1) ? $clog2(BCLK_HALF) : 1;
    localparam int unsigned LW = (LR_HALF > 1) ? $clog2(LR_HALF) : 1;
    localparam logic [HW-1:0] H_LAST = HW'(BCLK_HALF - 1);
    localparam logic [LW-1:0] L_LAST = LW'(LR_HALF - 1);

    typedef struct packed {
        apcs_ref_t     sel;
        logic          bclk;
        logic          lrclk;
        logic [HW-1:0] hcnt;
        logic [LW-1:0] lcnt;
    } apcs_gen_st_t;

    apcs_gen_st_t q;
    apcs_gen_st_t d;

    always_comb begin
        d = q;
        if (!gif.enable) begin
            d.bclk  = 1'b0;
            d.lrclk = 1'b0;
            d.hcnt  = '0;
            d.lcnt  = '0;
            d.sel   = gif.sel_req;
        end else if (!q.bclk && q.hcnt == '0 && gif.sel_req != q.sel) begin
            // Only at the start of a low phase, so no half period is cut short
            d.sel = gif.sel_req;
        end else if (gif.ref_edge[q.sel]) begin
            if (q.hcnt == H_LAST) begin
                d.hcnt = '0;
                d.bclk = ~q.bclk;
                if (q.bclk) begin
                    if (q.lcnt == L_LAST) begin
                        d.lcnt  = '0;
                        d.lrclk = ~q.lrclk;
                    end else begin
                        d.lcnt = q.lcnt + LW'(1);
                    end
                end
            end else begin
                d.hcnt = q.hcnt + HW'(1);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            q <= '{sel: APCS_REF_MCLK, bclk: 1'b0, lrclk: 1'b0, hcnt: '0, lcnt: '0};
        end else begin
            q <= d;
        end
    end

    assign gif.bclk       = q.bclk;
    assign gif.lrclk      = q.lrclk;
    assign gif.sel_active = q.sel;

    sel_switch_safe_a: assert property (@(posedge clock) disable iff (rst)
        gif.enable && $past(gif.enable) && $changed(q.sel) |-> $past(!q.bclk) && $past(q.hcnt) == '0)
        else $error("Reference switched outside a low phase start");

    gen_idle_low_a: assert property (@(posedge clock) disable iff (rst)
        !gif.enable |=> !q.bclk && !q.lrclk && q.sel == $past(gif.sel_req))
        else $error("Disabled generator not idle");

endmodule
`default_nettype wire

// File: rtl/apcs_top.sv
// Clock selection for the primary receive, primary transmit and secondary ports
`timescale 1ns/10ps
`default_nettype none
module apcs_top
    import apcs_pkg::*;
(
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rst,
    // Register access
    input  wire logic              reg_write,
    input  wire logic              reg_read,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    output var  logic [DATA_W-1:0] reg_rdata,
    // Routing and receiver state, same clock domain
    input  wire logic              spdif_rx_enabled,
    input  wire apcs_route_t       primary_tx_route,
    input  wire apcs_route_t       secondary_tx_route,
    // Reference clocks
    input  wire logic              main_clock_pin,
    input  wire logic              adc_main_clock_pin,
    input  wire logic              pll_a_output,
    input  wire logic              pll_b_output,
    // Primary receive pins
    input  wire logic              primary_rx_bit_clock_pin_in,
    output var  logic              primary_rx_bit_clock_pin_out,
    output var  logic              primary_rx_bit_clock_pin_oe_n,
    input  wire logic              primary_rx_frame_clock_pin_in,
    output var  logic              primary_rx_frame_clock_pin_out,
    output var  logic              primary_rx_frame_clock_pin_oe_n,
    // Primary transmit pin
    input  wire logic              primary_tx_bit_clock_pin_in,
    output var  logic              primary_tx_bit_clock_pin_out,
    output var  logic              primary_tx_bit_clock_pin_oe_n,
    // Secondary pins
    input  wire logic              secondary_bit_clock_pin_in,
    output var  logic              secondary_bit_clock_pin_out,
    output var  logic              secondary_bit_clock_pin_oe_n,
    input  wire logic              secondary_frame_clock_pin_in,
    output var  logic              secondary_frame_clock_pin_out,
    output var  logic              secondary_frame_clock_pin_oe_n,
    // Selected clocks to the port logic
    output var  logic              prx_bclk,
    output var  logic              prx_lrclk,
    output var  logic              ptx_bclk,
    output var  logic              ptx_lrclk,
    output var  logic              sec_bclk,
    output var  logic              sec_lrclk
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [NUM_SYNC-1:0] sync1;
        logic [NUM_SYNC-1:0] sync2;
        logic [NUM_SYNC-1:0] sync3;
        logic [DATA_W-1:0]   clock_source_select;
        logic [DATA_W-1:0]   prx_cfg;
        logic [DATA_W-1:0]   ptx_cfg;
        logic [DATA_W-1:0]   sec_cfg;
        logic [DATA_W-1:0]   rdata;
        logic                prx_bclk;
        logic                prx_lrclk;
        logic                ptx_bclk;
        logic                ptx_lrclk;
        logic                sec_bclk;
        logic                sec_lrclk;
        logic [4:0]          pin_out;
        logic [4:0]          pin_oe_n;
    } apcs_st_t;

    apcs_st_t q;
    apcs_st_t d;

    logic [NUM_SYNC-1:0] pins_in;
    logic [3:0]          ref_rise;
    logic                manual;
    logic                prx_master;
    logic                ptx_master;
    logic                sec_master;
    logic [1:0]          adc_field;
    apcs_ref_t           adc_src;
    apcs_ref_t           rx_req;
    apcs_ref_t           tx_req;
    apcs_ref_t           sec_req;

    apcs_gen_if gen_rx ();
    apcs_gen_if gen_tx ();
    apcs_gen_if gen_sec ();

    assign pins_in = {pll_b_output, pll_a_output, adc_main_clock_pin, main_clock_pin,
                      secondary_frame_clock_pin_in, secondary_bit_clock_pin_in,
                      primary_tx_bit_clock_pin_in, primary_rx_frame_clock_pin_in,
                      primary_rx_bit_clock_pin_in};

    // Rising edges of the references, seen after the second stage only
    assign ref_rise = q.sync2[PIN_REF_LSB +: 4] & ~q.sync3[PIN_REF_LSB +: 4];

    // ************************************************************
    // Reference selection
    // ************************************************************
    assign manual     = q.clock_source_select[BIT_MANUAL];
    assign prx_master = q.prx_cfg[BIT_MASTER];
    assign ptx_master = q.ptx_cfg[BIT_MASTER];
    assign sec_master = q.sec_cfg[BIT_MASTER];
    assign adc_field  = q.clock_source_select[FLD_ADC_LSB +: 2];

    // ADC source; outside manual mode a PLL pick falls back to its own pin while the PLLs are taken
    always_comb begin
        adc_src = apcs_dec_full(adc_field);
        if (!manual && spdif_rx_enabled && (adc_src == APCS_REF_PLLA || adc_src == APCS_REF_PLLB)) begin
            adc_src = APCS_REF_ADC;
        end
    end

    always_comb begin
        if (!manual && spdif_rx_enabled) begin
            rx_req = APCS_REF_MCLK;
        end else begin
            rx_req = apcs_dec_prx(q.prx_cfg[FLD_REF_LSB +: 2]);
        end
    end

    always_comb begin
        tx_req = apcs_dec_full(q.ptx_cfg[FLD_REF_LSB +: 2]);
        if (!manual) begin
            case (primary_tx_route)
                APCS_ROUTE_SPDIF_RX: tx_req = APCS_REF_PLLA;
                APCS_ROUTE_SEC_RX:   tx_req = adc_src;
                default: begin
                    if (spdif_rx_enabled && (tx_req == APCS_REF_PLLA || tx_req == APCS_REF_PLLB)) begin
                        tx_req = APCS_REF_MCLK;
                    end
                end
            endcase
        end
    end

    always_comb begin
        sec_req = apcs_dec_full(q.sec_cfg[FLD_REF_LSB +: 2]);
        if (!manual) begin
            if (secondary_tx_route == APCS_ROUTE_SPDIF_RX) begin
                sec_req = APCS_REF_PLLA;
            end else if (spdif_rx_enabled && (sec_req == APCS_REF_PLLA || sec_req == APCS_REF_PLLB)) begin
                sec_req = APCS_REF_MCLK;
            end
        end
    end

    // ************************************************************
    // Generators
    // ************************************************************
    assign gen_rx.enable    = prx_master;
    assign gen_rx.ref_edge  = ref_rise;
    assign gen_rx.sel_req   = rx_req;
    assign gen_tx.enable    = ptx_master;
    assign gen_tx.ref_edge  = ref_rise;
    assign gen_tx.sel_req   = tx_req;
    assign gen_sec.enable   = sec_master;
    assign gen_sec.ref_edge = ref_rise;
    assign gen_sec.sel_req  = sec_req;

    apcs_ref_gen u_gen_rx (
        .clock (clock),
        .rst   (rst),
        .gif   (gen_rx)
    );

    apcs_ref_gen u_gen_tx (
        .clock (clock),
        .rst   (rst),
        .gif   (gen_tx)
    );

    apcs_ref_gen u_gen_sec (
        .clock (clock),
        .rst   (rst),
        .gif   (gen_sec)
    );

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        d       = q;
        d.sync1 = pins_in;
        d.sync2 = q.sync1;
        d.sync3 = q.sync2;

        if (reg_write) begin
            case (reg_addr)
                ADDR_CLOCK_SOURCE_SELECT:  d.clock_source_select  = reg_wdata;
                ADDR_PRX_CFG: d.prx_cfg = reg_wdata;
                ADDR_PTX_CFG: d.ptx_cfg = reg_wdata;
                ADDR_SEC_CFG: d.sec_cfg = reg_wdata;
                default:      d.clock_source_select  = q.clock_source_select;
            endcase
        end

        // Unmapped reads return zero; data holds until the next read
        if (reg_read) begin
            case (reg_addr)
                ADDR_CLOCK_SOURCE_SELECT:  d.rdata = q.clock_source_select;
                ADDR_PRX_CFG: d.rdata = q.prx_cfg;
                ADDR_PTX_CFG: d.rdata = q.ptx_cfg;
                ADDR_SEC_CFG: d.rdata = q.sec_cfg;
                default:      d.rdata = '0;
            endcase
        end

        if (prx_master) begin
            d.prx_bclk  = gen_rx.bclk;
            d.prx_lrclk = gen_rx.lrclk;
        end else begin
            d.prx_bclk  = q.sync2[PIN_PRX_BCLK];
            d.prx_lrclk = q.sync2[PIN_PRX_LR];
        end

        if (ptx_master) begin
            d.ptx_bclk  = gen_tx.bclk;
            d.ptx_lrclk = gen_tx.lrclk;
        end else begin
            d.ptx_bclk  = (adc_field == ADC_ON_MCLK) ? q.sync2[PIN_PRX_BCLK] : q.sync2[PIN_PTX_BCLK];
            d.ptx_lrclk = q.sync2[PIN_PRX_LR];
        end

        // One pair serves both secondary directions
        if (sec_master) begin
            d.sec_bclk  = gen_sec.bclk;
            d.sec_lrclk = gen_sec.lrclk;
        end else begin
            d.sec_bclk  = q.sync2[PIN_SEC_BCLK];
            d.sec_lrclk = q.sync2[PIN_SEC_LR];
        end

        // Pins are driven only by a port in master mode
        d.pin_out  = {gen_sec.lrclk, gen_sec.bclk, gen_tx.bclk, gen_rx.lrclk, gen_rx.bclk};
        d.pin_oe_n = {~sec_master, ~sec_master, ~ptx_master, ~prx_master, ~prx_master};
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            q          <= '0;
            q.clock_source_select   <= RST_CLOCK_SOURCE_SELECT;
            q.prx_cfg  <= RST_PRX_CFG;
            q.ptx_cfg  <= RST_PTX_CFG;
            q.sec_cfg  <= RST_SEC_CFG;
            q.pin_oe_n <= 5'h1f;
        end else begin
            q <= d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign reg_rdata                       = q.rdata;
    assign prx_bclk                        = q.prx_bclk;
    assign prx_lrclk                       = q.prx_lrclk;
    assign ptx_bclk                        = q.ptx_bclk;
    assign ptx_lrclk                       = q.ptx_lrclk;
    assign sec_bclk                        = q.sec_bclk;
    assign sec_lrclk                       = q.sec_lrclk;
    assign primary_rx_bit_clock_pin_out    = q.pin_out[0];
    assign primary_rx_frame_clock_pin_out  = q.pin_out[1];
    assign primary_tx_bit_clock_pin_out    = q.pin_out[2];
    assign secondary_bit_clock_pin_out     = q.pin_out[3];
    assign secondary_frame_clock_pin_out   = q.pin_out[4];
    assign primary_rx_bit_clock_pin_oe_n   = q.pin_oe_n[0];
    assign primary_rx_frame_clock_pin_oe_n = q.pin_oe_n[1];
    assign primary_tx_bit_clock_pin_oe_n   = q.pin_oe_n[2];
    assign secondary_bit_clock_pin_oe_n    = q.pin_oe_n[3];
    assign secondary_frame_clock_pin_oe_n  = q.pin_oe_n[4];

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence prx_enter_master_s;
        !prx_master ##1 prx_master;
    endsequence

    sequence prx_pin_two_s;
        !prx_master ##1 !prx_master;
    endsequence

    prx_slave_pin_a: assert property (prx_pin_two_s |=>
        prx_bclk == $past(q.sync2[PIN_PRX_BCLK]) && prx_lrclk == $past(q.sync2[PIN_PRX_LR]))
        else $error("Slave primary receive not from pins");

    prx_master_gen_a: assert property (prx_enter_master_s |=>
        prx_bclk == $past(gen_rx.bclk) && !primary_rx_bit_clock_pin_oe_n)
        else $error("Master primary receive not from generator");

    prx_ref_force_a: assert property (!manual && spdif_rx_enabled |->
        rx_req == APCS_REF_MCLK)
        else $error("Primary receive reference not forced to MCLK");

    prx_ref_field_a: assert property (manual && q.prx_cfg[7] != q.prx_cfg[6] |->
        rx_req == (q.prx_cfg[7] ? APCS_REF_PLLB : APCS_REF_PLLA))
        else $error("Primary receive field decode wrong");

    ptx_bclk_src_a: assert property (!ptx_master && adc_field == ADC_ON_MCLK |=>
        ptx_bclk == $past(q.sync2[PIN_PRX_BCLK]))
        else $error("Transmit bit clock not from receive pin");

    ptx_frame_src_a: assert property (!ptx_master |=>
        ptx_lrclk == $past(q.sync2[PIN_PRX_LR]) && primary_tx_bit_clock_pin_oe_n)
        else $error("Transmit frame clock not from receive pin");

    ptx_auto_ref_a: assert property (!manual && primary_tx_route == APCS_ROUTE_SPDIF_RX |->
        tx_req == APCS_REF_PLLA)
        else $error("Transmit reference not PLL A");

    ptx_adc_ref_a: assert property (!manual && primary_tx_route == APCS_ROUTE_SEC_RX |->
        tx_req == adc_src)
        else $error("Transmit reference differs from ADC source");

    sec_limit_ref_a: assert property (!manual && spdif_rx_enabled &&
        secondary_tx_route != APCS_ROUTE_SPDIF_RX |->
        sec_req == APCS_REF_MCLK || sec_req == APCS_REF_ADC)
        else $error("Secondary reference uses an unavailable PLL");

    manual_field_a: assert property (manual |->
        sec_req == apcs_dec_full(q.sec_cfg[7:6]) && tx_req == apcs_dec_full(q.ptx_cfg[7:6]))
        else $error("Manual selection not following fields");

    // A new low phase must start on the requested reference
    sec_ref_follow_a: assert property (sec_master && $fell(gen_sec.bclk) |=>
        gen_sec.sel_active == $past(sec_req))
        else $error("Secondary generator ignores reference");

endmodule
`default_nettype wire

// File: shared/apcs_gen_if.sv
// Link between the select logic and one master-mode clock generator
`timescale 1ns/10ps
`default_nettype none
interface apcs_gen_if
    import apcs_pkg::*;
();
    logic       enable;
    logic [3:0] ref_edge;
    apcs_ref_t  sel_req;
    logic       bclk;
    logic       lrclk;
    apcs_ref_t  sel_active;

    modport ctrl (output enable, ref_edge, sel_req, input bclk, lrclk, sel_active);
    modport gen  (input enable, ref_edge, sel_req, output bclk, lrclk, sel_active);
endinterface
`default_nettype wire

// File: shared/apcs_pkg.sv
// Constants and types for the audio port clock select block
package apcs_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int unsigned ADDR_W       = 7;
    localparam int unsigned DATA_W       = 9;
    localparam logic [6:0]  ADDR_CLOCK_SOURCE_SELECT  = 7'h08;
    localparam logic [6:0]  ADDR_PRX_CFG = 7'h09;
    localparam logic [6:0]  ADDR_PTX_CFG = 7'h0a;
    localparam logic [6:0]  ADDR_SEC_CFG = 7'h0b;
    localparam logic [8:0]  RST_CLOCK_SOURCE_SELECT   = 9'h010;
    localparam logic [8:0]  RST_PRX_CFG  = 9'h000;
    localparam logic [8:0]  RST_PTX_CFG  = 9'h0c0;
    localparam logic [8:0]  RST_SEC_CFG  = 9'h0c0;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int unsigned BIT_MASTER   = 5;
    localparam int unsigned BIT_MANUAL   = 6;
    localparam int unsigned FLD_REF_LSB  = 6;
    localparam int unsigned FLD_ADC_LSB  = 2;
    localparam logic [1:0]  ADC_ON_MCLK  = 2'h3;

    // ************************************************************
    // Generator timing, in reference edges and bit clock periods
    // ************************************************************
    localparam int unsigned GEN_BCLK_HALF = 2;
    localparam int unsigned GEN_LR_HALF   = 32;

    // ************************************************************
    // Synchroniser slots; reference slots follow reference order
    // ************************************************************
    localparam int unsigned PIN_PRX_BCLK = 0;
    localparam int unsigned PIN_PRX_LR   = 1;
    localparam int unsigned PIN_PTX_BCLK = 2;
    localparam int unsigned PIN_SEC_BCLK = 3;
    localparam int unsigned PIN_SEC_LR   = 4;
    localparam int unsigned PIN_REF_LSB  = 5;
    localparam int unsigned NUM_SYNC     = 9;

    typedef enum logic [1:0] {
        APCS_REF_MCLK = 2'h0,
        APCS_REF_ADC  = 2'h1,
        APCS_REF_PLLA = 2'h2,
        APCS_REF_PLLB = 2'h3
    } apcs_ref_t;

    typedef enum logic [1:0] {
        APCS_ROUTE_OTHER    = 2'h0,
        APCS_ROUTE_SPDIF_RX = 2'h1,
        APCS_ROUTE_SEC_RX   = 2'h2,
        APCS_ROUTE_PRI_RX   = 2'h3
    } apcs_route_t;

    // Primary receive field: both 00 and 11 mean MCLK
    function automatic apcs_ref_t apcs_dec_prx(input logic [1:0] f);
        case (f)
            2'h1:    return APCS_REF_PLLA;
            2'h2:    return APCS_REF_PLLB;
            default: return APCS_REF_MCLK;
        endcase
    endfunction

    // Four-way field: 00 ADC pin, 01 PLL A, 10 PLL B, 11 MCLK
    function automatic apcs_ref_t apcs_dec_full(input logic [1:0] f);
        case (f)
            2'h0:    return APCS_REF_ADC;
            2'h1:    return APCS_REF_PLLA;
            2'h2:    return APCS_REF_PLLB;
            default: return APCS_REF_MCLK;
        endcase
    endfunction

endpackage
